//--- logic/emw_pkg.sv
// Purpose: shared constants, types and check-code function of the ECC memory word path
// Assumes: 100 MHz core clock, 22-bit stored words (16 data + 6 check)
// Notes: rules carried by this block follow
package emw_pkg;
  localparam int DATA_W = 16;
  localparam int CHK_W = 6;
  localparam int WORD_W = 22;
  localparam int ADDR_W = 22;
  localparam int PAIR_AW = 19;
  localparam int CLK_NS = 10;
  // refresh interval, nominal figure
  localparam int REF_NS = 14000;
  localparam int REF_CYC = REF_NS / CLK_NS;
  localparam int REF_BUSY_CYC = 4;
  // longest allowed lengthening by correction
  localparam int CORR_MAX_NS = 116;
  localparam int CORR_MAX_CYC = CORR_MAX_NS / CLK_NS;
  localparam int CORR_STALL_CYC = 1;
  // nominal strobe delay after bus cycle start
  localparam int WSTB_NOM_NS = 145;
  localparam int WSTB_NOM_CYC = WSTB_NOM_NS / CLK_NS;
  localparam logic [2:0] BLK_LAST = 3'h7;
  localparam logic [ADDR_W-1:0] CSR_DEFAULT = 22'o17772100;
  localparam logic [ADDR_W-1:0] PAIR_STEP = 22'h4;
  localparam logic [ADDR_W-1:0] WORD_STEP = 22'h2;
  // one distinct column of weight two or three per data bit, bit 0 lowest
  localparam logic [79:0] ECC_COLS = {5'h15, 5'h13, 5'h0e, 5'h0d, 5'h0b, 5'h07, 5'h18, 5'h14,
                                      5'h12, 5'h11, 5'h0c, 5'h0a, 5'h09, 5'h06, 5'h05, 5'h03};

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_FETCH   = 4'h1,
    ST_CHECK   = 4'h2,
    ST_STALL   = 4'h3,
    ST_SEND1   = 4'h4,
    ST_SEND2   = 4'h5,
    ST_BLKWAIT = 4'h6,
    ST_WAITSTB = 4'h7,
    ST_REPLY   = 4'h8,
    ST_BPNEXT  = 4'h9,
    ST_REFRESH = 4'ha,
    ST_DONE    = 4'hb
  } emw_state_t;

  typedef struct packed {
    logic bp;
    logic write;
    logic [1:0] bmask;
    logic block;
    logic [ADDR_W-1:0] addr;
  } emw_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic sbe;
    logic mbe;
  } emw_fix_t;

  function automatic logic [CHK_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    c = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (d[i]) begin
        c[4:0] = c[4:0] ^ ECC_COLS[i*5 +: 5];
      end
    end
    c[5] = (^d) ^ (^c[4:0]);
    return c;
  endfunction
endpackage

//--- logic/emw_ecc.sv
// Purpose: checks one stored 22-bit word and returns corrected data and flags
// Assumes: check bits in the upper 6 bits, data in the lower 16
// Notes: purely combinational, used once per word of a fetched pair
`timescale 1ns/1ps
`default_nettype none
module emw_ecc
  import emw_pkg::*;
(
  // stored word
  input wire logic [WORD_W-1:0] word,
  // result
  output emw_fix_t fix
);
  logic [DATA_W-1:0] raw;
  logic [CHK_W-1:0] gen;
  logic [4:0] syn;
  logic par;
  logic [DATA_W-1:0] flip;
  logic hit;
  logic single_chk;

  assign raw = word[DATA_W-1:0];
  assign gen = ecc_gen(raw);
  assign syn = gen[4:0] ^ word[DATA_W +: 5];
  assign par = ^word;
  assign single_chk = (syn & (syn - 5'h01)) == 5'h00;

  always_comb begin
    flip = '0;
    hit = 1'b0;
    for (int i = 0; i < DATA_W; i++) begin
      if (syn == ECC_COLS[i*5 +: 5]) begin
        flip[i] = 1'b1;
        hit = 1'b1;
      end
    end
  end

  // even parity with nonzero syndrome, or odd parity with no matching column and two or more syndrome bits, is multi
  assign fix.mbe = (!par && syn != 5'h00) || (par && !hit && !single_chk);
  assign fix.sbe = par && !fix.mbe;
  assign fix.data = fix.mbe ? raw : (raw ^ flip);
endmodule
`default_nettype wire

//--- logic/emw_mem.sv
// Purpose: storage array of even/odd word pairs with registered read data
// Assumes: one read or one single-lane write per clock
// Notes: no reset on the array itself, as on real dynamic RAM
`timescale 1ns/1ps
`default_nettype none
module emw_mem
  import emw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access
  input wire logic rd,
  input wire logic wr,
  input wire logic wr_lane,
  input wire logic [PAIR_AW-1:0] addr,
  input wire logic [WORD_W-1:0] wdata,
  // pair out, odd word in upper half
  output logic [2*WORD_W-1:0] rdata
);
  // each of the two 22-bit lanes kept whole
  logic [WORD_W-1:0] even_arr [2**PAIR_AW];
  logic [WORD_W-1:0] odd_arr [2**PAIR_AW];

  always_ff @(posedge clk) begin
    if (wr && !wr_lane) begin
      even_arr[addr] <= wdata;
    end
    if (wr && wr_lane) begin
      odd_arr[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= {odd_arr[addr], even_arr[addr]};
    end
  end
endmodule
`default_nettype wire

//--- logic/emw_top.sv
// Purpose: ECC memory word path with processor-bus and backplane-bus cycles
// Assumes: bus inputs synchronous to core_clk; one request at a time
// Notes: refresh is slotted between bus cycles only
`timescale 1ns/1ps
`default_nettype none
module emw_top
  import emw_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // board options
  input wire logic full_variant,
  input wire logic [3:0] csr_switch,
  // processor bus request
  input wire logic proc_bus_cycle,
  input wire logic proc_write,
  input wire logic [1:0] proc_byte_en,
  input wire logic proc_block,
  input wire logic [ADDR_W-1:0] proc_addr,
  input wire logic proc_write_strobe,
  input wire logic [DATA_W-1:0] proc_wdata,
  input wire logic proc_block_continue,
  // processor bus answer
  output logic proc_slave_selected,
  output logic proc_read_data_strobe,
  output logic [DATA_W-1:0] proc_rdata,
  output logic proc_data_invalid,
  output logic mem_busy,
  // backplane bus request
  input wire logic bp_sync,
  input wire logic bp_din,
  input wire logic bp_dout,
  input wire logic bp_block,
  input wire logic bp_write,
  input wire logic [1:0] bp_byte_en,
  input wire logic [ADDR_W-1:0] bp_addr,
  input wire logic [DATA_W-1:0] bp_wdata,
  // backplane bus answer
  output logic bp_reply,
  output logic [DATA_W-1:0] bp_rdata,
  output logic bp_data_invalid,
  // status
  output logic err_single,
  output logic err_multi,
  output logic csr_hit,
  output logic refresh_active
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // state and request capture
  // ----------------------------------------
  emw_state_t state;
  emw_state_t next_state;
  emw_req_t req;
  emw_req_t next_req;
  logic [2:0] blk_cnt;
  logic [2:0] next_blk_cnt;
  logic [2:0] ref_busy;
  logic [2:0] next_ref_busy;

  logic next_proc_slave_selected;
  logic next_proc_read_data_strobe;
  logic [DATA_W-1:0] next_proc_rdata;
  logic next_proc_data_invalid;
  logic next_bp_reply;
  logic [DATA_W-1:0] next_bp_rdata;
  logic next_bp_data_invalid;
  logic next_err_single;
  logic next_err_multi;
  logic next_csr_hit;

  // ----------------------------------------
  // address decode and data selection
  // ----------------------------------------
  logic [ADDR_W-1:0] csr_addr;
  logic proc_take;
  logic bp_take;
  logic word_select_addr_bit;
  logic even_odd_addr_bit;
  logic [2*WORD_W-1:0] pair_rdata;
  emw_fix_t fix_even;
  emw_fix_t fix_odd;
  emw_fix_t fix_first;
  emw_fix_t fix_second;
  logic wstb;
  logic [DATA_W-1:0] wdata_in;
  logic [DATA_W-1:0] merged;
  logic mem_rd;
  logic mem_wr;
  logic byte_write;

  // switches step the word address from the default
  assign csr_addr = CSR_DEFAULT + ADDR_W'({csr_switch, 1'b0});
  assign proc_take = proc_bus_cycle;
  assign bp_take = bp_sync && full_variant && !proc_bus_cycle;
  // bit 1 chooses the first or only word
  assign word_select_addr_bit = req.addr[1];
  assign even_odd_addr_bit = next_req.addr[1];
  assign fix_first = word_select_addr_bit ? fix_odd : fix_even;
  assign fix_second = word_select_addr_bit ? fix_even : fix_odd;
  assign wstb = req.bp ? bp_dout : proc_write_strobe;
  assign wdata_in = req.bp ? bp_wdata : proc_wdata;
  assign byte_write = req.bmask != 2'h3;
  // merge new byte over corrected old word
  assign merged = {req.bmask[1] ? wdata_in[15:8] : fix_first.data[15:8],
                   req.bmask[0] ? wdata_in[7:0] : fix_first.data[7:0]};
  assign mem_rd = state == ST_FETCH;
  assign mem_wr = state == ST_WAITSTB && wstb;

  // ----------------------------------------
  // array and checkers
  // ----------------------------------------
  // check bits stored with the data
  emw_mem u_mem (
    .clk(core_clk),
    .rst_n(rst_n),
    .rd(mem_rd),
    .wr(mem_wr),
    .wr_lane(word_select_addr_bit),
    .addr(req.addr[PAIR_AW+1:2]),
    .wdata({ecc_gen(merged), merged}),
    .rdata(pair_rdata)
  );

  // corrected data goes to the bus and into byte-write merges
  emw_ecc u_ecc_even (
    .word(pair_rdata[WORD_W-1:0]),
    .fix(fix_even)
  );

  emw_ecc u_ecc_odd (
    .word(pair_rdata[2*WORD_W-1:WORD_W]),
    .fix(fix_odd)
  );

  // ----------------------------------------
  // refresh timer
  // ----------------------------------------
  logic [10:0] ref_cnt;
  logic ref_tick;
  logic ref_pend;
  logic ref_start;

  assign ref_tick = ref_cnt == 11'(REF_CYC - 1);
  assign ref_start = state == ST_IDLE && ref_pend;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt <= '0;
      ref_pend <= 1'b0;
    end else begin
      ref_cnt <= ref_tick ? 11'h000 : ref_cnt + 11'h001;
      // a tick in the taking cycle stays pending
      ref_pend <= ref_tick || (ref_pend && !ref_start);
    end
  end

  // ----------------------------------------
  // cycle sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_req = req;
    next_blk_cnt = blk_cnt;
    next_ref_busy = ref_busy;
    next_proc_slave_selected = 1'b0;
    next_proc_read_data_strobe = 1'b0;
    next_proc_rdata = proc_rdata;
    next_proc_data_invalid = proc_data_invalid;
    next_bp_reply = bp_reply;
    next_bp_rdata = bp_rdata;
    next_bp_data_invalid = bp_data_invalid;
    next_err_single = 1'b0;
    next_err_multi = 1'b0;
    next_csr_hit = 1'b0;
    case (state)
      ST_IDLE: begin
        if (ref_pend) begin
          next_ref_busy = 3'(REF_BUSY_CYC - 1);
          next_state = ST_REFRESH;
        end else if (proc_take || bp_take) begin
          next_req = proc_take ? '{bp: 1'b0, write: proc_write, bmask: proc_byte_en, block: proc_block,
                                   addr: proc_addr}
                               : '{bp: 1'b1, write: bp_write, bmask: bp_byte_en, block: bp_block,
                                   addr: bp_addr};
          next_blk_cnt = 3'h0;
          if (next_req.addr == csr_addr) begin
            next_csr_hit = 1'b1;
            next_state = ST_DONE;
          end else begin
            next_proc_slave_selected = proc_take;
            // write begins at address, before strobe
            if (next_req.write && next_req.bmask == 2'h3) begin
              next_state = ST_WAITSTB;
            end else begin
              next_state = ST_FETCH;
            end
          end
        end
      end
      ST_FETCH: begin
        next_state = ST_CHECK;
      end
      ST_CHECK: begin
        next_err_single = fix_first.sbe || (!req.bp && !req.write && fix_second.sbe);
        next_err_multi = fix_first.mbe || (!req.bp && !req.write && fix_second.mbe);
        if (req.write) begin
          next_state = ST_WAITSTB;
        end else if (req.bp) begin
          next_bp_rdata = fix_first.data;
          next_bp_data_invalid = fix_first.mbe;
          next_bp_reply = 1'b1;
          next_state = ST_REPLY;
        end else if (fix_first.sbe) begin
          // one cycle, well inside the limit
          next_state = ST_STALL;
        end else begin
          next_proc_read_data_strobe = 1'b1;
          next_proc_rdata = fix_first.data;
          next_proc_data_invalid = fix_first.mbe;
          next_state = ST_SEND1;
        end
      end
      ST_STALL: begin
        next_proc_read_data_strobe = 1'b1;
        next_proc_rdata = fix_first.data;
        next_proc_data_invalid = fix_first.mbe;
        next_state = ST_SEND1;
      end
      ST_SEND1: begin
        next_proc_read_data_strobe = 1'b1;
        next_proc_rdata = fix_second.data;
        next_proc_data_invalid = fix_second.mbe;
        next_state = ST_SEND2;
      end
      ST_SEND2: begin
        if (req.block && blk_cnt != BLK_LAST) begin
          next_state = ST_BLKWAIT;
        end else begin
          next_state = ST_DONE;
        end
      end
      ST_BLKWAIT: begin
        if (proc_block_continue) begin
          next_blk_cnt = blk_cnt + 3'h1;
          next_req.addr = req.addr + PAIR_STEP;
          next_state = ST_FETCH;
        end else if (!proc_bus_cycle) begin
          next_state = ST_IDLE;
        end
      end
      ST_WAITSTB: begin
        // late strobe simply stretches this wait
        if (wstb) begin
          if (req.bp) begin
            next_bp_reply = 1'b1;
            next_state = ST_REPLY;
          end else begin
            next_state = ST_DONE;
          end
        end else if (req.bp ? !bp_sync : !proc_bus_cycle) begin
          next_state = ST_IDLE;
        end
      end
      ST_REPLY: begin
        if (!bp_din && !bp_dout) begin
          next_bp_reply = 1'b0;
          next_state = (req.block && !req.write && bp_sync) ? ST_BPNEXT : ST_DONE;
        end
      end
      ST_BPNEXT: begin
        if (!bp_sync) begin
          next_state = ST_IDLE;
        end else if (bp_din) begin
          next_req.addr = req.addr + WORD_STEP;
          // odd word reuses the latched pair
          next_state = even_odd_addr_bit ? ST_CHECK : ST_FETCH;
        end
      end
      ST_REFRESH: begin
        next_ref_busy = ref_busy - 3'h1;
        if (ref_busy == 3'h0) begin
          next_state = ST_IDLE;
        end
      end
      ST_DONE: begin
        if (req.bp ? !bp_sync : !proc_bus_cycle) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      req <= '0;
      blk_cnt <= '0;
      ref_busy <= '0;
    end else begin
      state <= next_state;
      req <= next_req;
      blk_cnt <= next_blk_cnt;
      ref_busy <= next_ref_busy;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      proc_slave_selected <= 1'b0;
      proc_read_data_strobe <= 1'b0;
      proc_rdata <= '0;
      proc_data_invalid <= 1'b0;
      mem_busy <= 1'b0;
      bp_reply <= 1'b0;
      bp_rdata <= '0;
      bp_data_invalid <= 1'b0;
      err_single <= 1'b0;
      err_multi <= 1'b0;
      csr_hit <= 1'b0;
      refresh_active <= 1'b0;
    end else begin
      proc_slave_selected <= next_proc_slave_selected;
      proc_read_data_strobe <= next_proc_read_data_strobe;
      proc_rdata <= next_proc_rdata;
      proc_data_invalid <= next_proc_data_invalid;
      // busy drops when the memory has finished its part
      mem_busy <= next_state != ST_IDLE && next_state != ST_DONE;
      bp_reply <= next_bp_reply;
      bp_rdata <= next_bp_rdata;
      bp_data_invalid <= next_bp_data_invalid;
      err_single <= next_err_single;
      err_multi <= next_err_multi;
      csr_hit <= next_csr_hit;
      refresh_active <= next_state == ST_REFRESH;
    end
  end
endmodule
`default_nettype wire

//--- verif/emw_asserts.sv
// Purpose: port checks of emw_top
// Assumes: proc_write low outside processor cycles
// Notes: bound from tb_top
`timescale 1ns/1ps
`default_nettype none
module emw_asserts
  import emw_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // watched signals
  input wire logic full_variant,
  input wire logic proc_bus_cycle,
  input wire logic proc_write,
  input wire logic proc_write_strobe,
  input wire logic proc_slave_selected,
  input wire logic proc_read_data_strobe,
  input wire logic mem_busy,
  input wire logic bp_din,
  input wire logic bp_dout,
  input wire logic bp_reply,
  input wire logic err_single,
  input wire logic err_multi,
  input wire logic refresh_active
);
  // ----
  // checks
  // ----
  logic [4:0] strb_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // strobes counted per busy span
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) strb_cnt <= '0;
    else if (!mem_busy) strb_cnt <= '0;
    else if (proc_read_data_strobe) strb_cnt <= strb_cnt + 5'h1;
  end
  sequence s_first_word;
    proc_read_data_strobe && !$past(proc_read_data_strobe);
  endsequence
  sequence s_second_word;
    proc_read_data_strobe ##1 !proc_read_data_strobe;
  endsequence
  AST_RD_PAIR: assert property (s_first_word |=> s_second_word) else $error("read word not paired");
  AST_RD_LAT: assert property (proc_slave_selected && !proc_write |->
    !proc_read_data_strobe [*2] ##[1:2] proc_read_data_strobe) else $error("read latency wrong");
  AST_WR_START: assert property ($rose(mem_busy) && proc_write && !proc_write_strobe && !refresh_active |->
    proc_slave_selected) else $error("write not started early");
  AST_WR_STRETCH: assert property (mem_busy && proc_write && proc_bus_cycle && !proc_write_strobe
    && !refresh_active |=> mem_busy) else $error("write ended before strobe");
  AST_BLK_COUNT: assert property ($fell(mem_busy) |->
    strb_cnt == 5'h0 || strb_cnt == 5'h2 || strb_cnt == 5'h10) else $error("bad word count");
  AST_BP_SILENT: assert property (!full_variant && $past(!full_variant) |-> !bp_reply)
    else $error("reduced board replied");
  AST_BP_STAND: assert property (bp_reply && (bp_din || bp_dout) |=> bp_reply)
    else $error("reply dropped early");
  AST_BP_DROP: assert property (bp_reply && !bp_din && !bp_dout |=> !bp_reply)
    else $error("reply held too long");
  AST_REF_SLOT: assert property ($rose(refresh_active) |-> refresh_active [*4] ##1 !refresh_active)
    else $error("refresh slot length");
  AST_REF_QUIET: assert property (refresh_active |->
    !proc_read_data_strobe && !proc_slave_selected && !bp_reply) else $error("refresh inside cycle");
  AST_ERR_EXCL: assert property (err_single |-> !err_multi) else $error("both error kinds");
endmodule
`default_nettype wire

//--- verif/emw_proc_master.sv
// Purpose: processor-bus master model
// Assumes: answers sampled on the falling edge
// Notes: continue comes promptly or late at random
`timescale 1ns/1ps
`default_nettype none
module emw_proc_master
  import emw_pkg::*;
(
  // clock
  input wire logic core_clk,
  // request
  output logic proc_bus_cycle,
  output logic proc_write,
  output logic [1:0] proc_byte_en,
  output logic proc_block,
  output logic [ADDR_W-1:0] proc_addr,
  output logic proc_write_strobe,
  output logic [DATA_W-1:0] proc_wdata,
  output logic proc_block_continue,
  // answer
  input wire logic proc_read_data_strobe,
  input wire logic [DATA_W-1:0] proc_rdata,
  input wire logic proc_data_invalid,
  input wire logic mem_busy,
  input wire logic proc_slave_selected
);
  // ----
  // drivers
  // ----
  initial begin
    {proc_bus_cycle, proc_write, proc_byte_en, proc_block, proc_write_strobe} = '0;
    proc_block_continue = 1'b0;
    proc_addr = '0;
    proc_wdata = '0;
  end
  always @(posedge core_clk) begin
    proc_block_continue <= proc_block && ($urandom % 3 == 0);
  end
  task automatic start(input logic w, input logic [1:0] be, input logic blk, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    proc_bus_cycle <= 1'b1;
    proc_write <= w;
    proc_byte_en <= be;
    proc_block <= blk;
    proc_addr <= a;
    proc_wdata <= d;
  endtask
  // released address and data lines show inverted last value
  task automatic end_cycle();
    @(posedge core_clk);
    {proc_bus_cycle, proc_write, proc_block, proc_write_strobe} <= '0;
    proc_addr <= ~proc_addr;
    proc_wdata <= ~proc_wdata;
    @(posedge core_clk);
  endtask
  // strobe trails the address by dly cycles
  task automatic wr(input logic [1:0] be, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input int dly);
    bit seen;
    start(1'b1, be, 1'b0, a, d);
    repeat (dly) @(posedge core_clk);
    proc_write_strobe <= 1'b1;
    seen = 0;
    for (int n = 0; n < 300 && !(seen && mem_busy === 1'b0); n++) begin
      @(negedge core_clk);
      // a refresh slot before the take also raises busy
      seen |= (proc_slave_selected === 1'b1);
    end
    end_cycle();
  endtask
  task automatic rd(input logic blk, input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q[$], output logic inv);
    q = {};
    inv = 1'b0;
    start(1'b0, 2'h3, blk, a, '0);
    for (int n = 0; n < 600 && q.size() < (blk ? 16 : 2); n++) begin
      @(negedge core_clk);
      if (proc_read_data_strobe === 1'b1) begin
        q.push_back(proc_rdata);
        inv = inv | proc_data_invalid;
      end
    end
    end_cycle();
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: self-checking bench of emw_top
// Assumes: faults injected straight into the array model
// Notes: expected words kept in a sparse model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import emw_pkg::*;
  logic core_clk, arst_n, full_variant, bp_sync, bp_din, bp_dout, bp_block, bp_write;
  logic [3:0] csr_switch;
  logic [1:0] proc_byte_en, bp_byte_en;
  logic [ADDR_W-1:0] proc_addr, bp_addr;
  logic [DATA_W-1:0] proc_wdata, bp_wdata, proc_rdata, bp_rdata;
  logic proc_bus_cycle, proc_write, proc_block, proc_write_strobe, proc_block_continue;
  logic proc_slave_selected, proc_read_data_strobe, proc_data_invalid, mem_busy;
  logic bp_reply, bp_data_invalid, err_single, err_multi, csr_hit, refresh_active;
  logic [DATA_W-1:0] ref_mem [int];
  int error_cnt = 0, n_checks = 0, csr_cnt = 0, flag_cnt = 0, ref_rise = 0;
  // ----
  // instances
  // ----
  emw_top u_emw_top (.core_clk, .arst_n, .full_variant, .csr_switch, .proc_bus_cycle, .proc_write,
    .proc_byte_en, .proc_block, .proc_addr, .proc_write_strobe, .proc_wdata, .proc_block_continue,
    .proc_slave_selected, .proc_read_data_strobe, .proc_rdata, .proc_data_invalid, .mem_busy, .bp_sync,
    .bp_din, .bp_dout, .bp_block, .bp_write, .bp_byte_en, .bp_addr, .bp_wdata, .bp_reply, .bp_rdata,
    .bp_data_invalid, .err_single, .err_multi, .csr_hit, .refresh_active);
  emw_proc_master u_emw_proc_master (.core_clk, .proc_bus_cycle, .proc_write, .proc_byte_en, .proc_block,
    .proc_addr, .proc_write_strobe, .proc_wdata, .proc_block_continue, .proc_read_data_strobe,
    .proc_rdata, .proc_data_invalid, .mem_busy, .proc_slave_selected);
  // ----
  // helpers
  // ----
  always #5 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    csr_cnt += int'(csr_hit === 1'b1);
    flag_cnt += int'(err_single === 1'b1) + int'(err_multi === 1'b1) + int'(bp_data_invalid === 1'b1);
  end
  always @(posedge refresh_active) ref_rise++;
  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n, input logic [1:0] be);
    return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
  endfunction
  function automatic int exp_idx(input logic [ADDR_W-1:0] a, input int i);
    return ((int'(a) >> 2) + i / 2) * 2 + ((i % 2) ^ int'(a[1]));
  endfunction
  function automatic logic [ADDR_W-1:0] csr_addr(input logic [3:0] sw);
    return CSR_DEFAULT + {17'h0, sw, 1'b0};
  endfunction
  task automatic pwr(input logic [1:0] be, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input int dly);
    int k;
    k = int'(a) >> 1;
    u_emw_proc_master.wr(be, a, d, dly);
    ref_mem[k] = merge(ref_mem.exists(k) ? ref_mem[k] : '0, d, be);
  endtask
  task automatic prd(input logic blk, input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] q[$];
    logic inv;
    u_emw_proc_master.rd(blk, a, q, inv);
    check(q.size(), blk ? 16 : 2);
    check(inv, 1'b0);
    foreach (q[i]) check(q[i], ref_mem[exp_idx(a, i)]);
  endtask
  task automatic bp_beat(input logic w, blk, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         output logic [DATA_W-1:0] q, output int lat);
    @(posedge core_clk);
    bp_sync <= 1'b1;
    bp_write <= w;
    bp_block <= blk;
    bp_addr <= a;
    bp_wdata <= d;
    bp_din <= !w;
    bp_dout <= w;
    lat = 0;
    do begin
      @(negedge core_clk);
      lat++;
    end while (bp_reply !== 1'b1 && lat < 40);
    q = bp_rdata;
    @(posedge core_clk);
    bp_din <= 1'b0;
    bp_dout <= 1'b0;
    for (int n = 0; n < 20 && bp_reply !== 1'b0; n++) @(negedge core_clk);
  endtask
  task automatic bp_end();
    @(posedge core_clk);
    bp_sync <= 1'b0;
    bp_block <= 1'b0;
    bp_addr <= ~bp_addr;
    bp_wdata <= ~bp_wdata;
    @(posedge core_clk);
  endtask
  // ----
  // tests
  // ----
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
  initial begin
    logic [ADDR_W-1:0] p;
    logic [DATA_W-1:0] q;
    int lat[4];
    {core_clk, arst_n, bp_sync, bp_din, bp_dout, bp_block, bp_write} = '0;
    full_variant = 1'b1;
    csr_switch = '0;
    bp_byte_en = 2'h3;
    bp_addr = '0;
    bp_wdata = '0;
    void'($urandom(3));
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    // early, late and byte writes, read back in both orders
    for (int i = 0; i < 6; i++) begin
      p = 22'($urandom % 64) << 2;
      pwr(2'h3, p, 16'($urandom), i == 0 ? 16 : int'($urandom % 20));
      pwr(2'h3, p | 22'h2, 16'($urandom), 0);
      pwr(i % 2 ? 2'h1 : 2'h2, p | 22'(i % 2 << 1), 16'($urandom), 1);
      prd(1'b0, p | 22'(i % 4 / 2 << 1));
    end
    for (int k = 0; k < 16; k++) pwr(2'h3, 22'h400 + 22'(2 * k), 16'($urandom), 0);
    prd(1'b1, 22'h400);
    // even words refetch, odd words from the held pair
    for (int k = 0; k < 4; k++) begin
      bp_beat(1'b0, 1'b1, 22'h400 + 22'(2 * k), '0, q, lat[k]);
      check(q, ref_mem[32'h200 + k]);
    end
    bp_end();
    check(lat[2] - lat[1], 1);
    check(lat[3], lat[1]);
    bp_beat(1'b1, 1'b0, 22'h402, 16'h5aa5, q, lat[0]);
    bp_end();
    ref_mem[32'h201] = 16'h5aa5;
    bp_beat(1'b0, 1'b0, 22'h402, '0, q, lat[0]);
    bp_end();
    check(q, 16'h5aa5);
    prd(1'b0, 22'h402);
    full_variant <= 1'b0;
    bp_beat(1'b0, 1'b0, 22'h400, '0, q, lat[0]);
    bp_end();
    check(lat[0], 40);
    full_variant <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      csr_switch <= s ? 4'($urandom) : 4'h0;
      @(posedge core_clk);
      bp_beat(1'b0, 1'b0, csr_addr(csr_switch), '0, q, lat[0]);
      bp_end();
    end
    check(csr_cnt, 2);
    check(flag_cnt, 0);
    repeat (2 * REF_CYC) @(posedge core_clk);
    check(int'(ref_rise > 0), 1);
    // array faults: one bit in a first word, then two bits in an odd word
    u_emw_top.u_mem.even_arr[19'h100] ^= 22'h8;
    repeat (2) prd(1'b0, 22'h400);
    check(flag_cnt, 2);
    u_emw_top.u_mem.odd_arr[19'h100] ^= 22'h3;
    bp_beat(1'b0, 1'b0, 22'h402, '0, q, lat[0]);
    check(q, ref_mem[32'h201] ^ 16'h3);
    check(bp_data_invalid, 1'b1);
    bp_end();
    summarize();
  end
endmodule
bind emw_top emw_asserts u_emw_asserts (.core_clk, .arst_n, .full_variant, .proc_bus_cycle, .proc_write,
  .proc_write_strobe, .proc_slave_selected, .proc_read_data_strobe, .mem_busy, .bp_din, .bp_dout, .bp_reply,
  .err_single, .err_multi, .refresh_active);
`default_nettype wire
